/* common/supply_detect_cfg.svh */
`ifndef SUPPLY_DETECT_CFG_SVH
`define SUPPLY_DETECT_CFG_SVH

// Register indices; byte address is four times the index
`define SD_IDX_CTRL 16'h0f85
`define SD_IDX_STATUS 16'h0f86
`define SD_IDX_MASK 16'h0f87
`define SD_ADDR_CTRL (`SD_IDX_CTRL << 2)
`define SD_ADDR_STATUS (`SD_IDX_STATUS << 2)
`define SD_ADDR_MASK (`SD_IDX_MASK << 2)

// Control register fields
`define SD_BIT_DIR 7
`define SD_BIT_BG 6
`define SD_BIT_REF 5
`define SD_BIT_EN 4
`define SD_LVL_MSB 3
`define SD_LVL_LSB 0
`define SD_LVL_EXT 4'hf
`define SD_CTRL_RST 8'h00

// Status and mask fields, same layout
`define SD_BIT_EVENT 0
`define SD_STATUS_RST 1'b0
`define SD_MASK_RST 1'b0

// Reference settling time and its cycle count at 100 ns per clock
`define SD_T_STAB_NS 20000
`define SD_CLK_PERIOD_NS 100
`define SD_STAB_CYC ((`SD_T_STAB_NS + `SD_CLK_PERIOD_NS - 1) / `SD_CLK_PERIOD_NS)
`define SD_STAB_W 8

`endif

/* common/supply_detect_pkg.sv */
package supply_detect_pkg;

    typedef enum logic [1:0] {
        DET_OFF,
        DET_SETTLE,
        DET_ARMED
    } det_state_t;

    typedef logic [3:0] trip_level_t;
    typedef logic [15:0] apb_addr_t;
    typedef logic [31:0] apb_data_t;

endpackage : supply_detect_pkg

/* hw/pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [W-1:0] raw,
    output logic [W-1:0] clean
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end else begin
            stage1 <= raw;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    // A level is taken only once two settled stages agree
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            clean <= '0;
        end else begin
            clean <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & clean);
        end
    end

endmodule : pin_sync

`default_nettype wire

/* hw/stable_timer.sv */
`timescale 1ns/100ps
`default_nettype none

module stable_timer #(
    parameter int COUNT = 200,
    parameter int W = 8
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic run,
    output logic done
);

    localparam logic [W-1:0] LAST = W'(COUNT - 1);

    logic [W-1:0] cnt;

    // Dropping run restarts the interval from zero
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= '0;
            done <= 1'b0;
        end else if (!run) begin
            cnt <= '0;
            done <= 1'b0;
        end else if (cnt == LAST) begin
            done <= 1'b1;
        end else begin
            cnt <= cnt + W'(1);
        end
    end

endmodule : stable_timer

`default_nettype wire

/* hw/supply_threshold_detect_ctrl.sv */
`include "supply_detect_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module supply_threshold_detect_ctrl (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire supply_detect_pkg::apb_addr_t paddr,
    input wire supply_detect_pkg::apb_data_t pwdata,
    output supply_detect_pkg::apb_data_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cmpAtOrAbove,
    input wire logic cmpAtOrBelow,
    input wire logic bandgapReady,
    output logic detectorPowerOn,
    output supply_detect_pkg::trip_level_t tripLevelSel,
    output logic externalInputSel,
    output logic directionSel,
    output logic irq,
    output logic wakeRequest
);

    import supply_detect_pkg::*;

    localparam int STAB = `SD_STAB_CYC;

    det_state_t state;
    det_state_t next_state;

    logic syncAbove;
    logic syncBelow;
    logic bgStable;
    logic timerDone;
    logic refStable;
    logic eventFlag;
    logic intEnable;
    logic next_eventFlag;
    logic next_intEnable;
    logic next_powerOn;
    logic next_direction;
    trip_level_t next_level;
    logic trip;

    logic setupPhase;
    logic accessDone;
    logic hitCtrl;
    logic hitStatus;
    logic hitMask;
    logic wrCtrl;
    logic wrStatus;
    logic wrMask;
    apb_data_t readMux;

    // Analog comparator and band gap status arrive unsynchronised
    pin_sync #(
        .W(3)
    ) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .raw({cmpAtOrAbove, cmpAtOrBelow, bandgapReady}),
        .clean({syncAbove, syncBelow, bgStable})
    );

    stable_timer #(
        .COUNT(STAB),
        .W(`SD_STAB_W)
    ) u_timer (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .run(state == DET_SETTLE && detectorPowerOn),
        .done(timerDone)
    );

    // APB slave: pready follows the setup cycle, so each access lasts two cycles
    assign setupPhase = psel && !penable;
    assign accessDone = psel && penable && pready;
    assign hitCtrl = (paddr == `SD_ADDR_CTRL);
    assign hitStatus = (paddr == `SD_ADDR_STATUS);
    assign hitMask = (paddr == `SD_ADDR_MASK);
    assign wrCtrl = accessDone && pwrite && hitCtrl;
    assign wrStatus = accessDone && pwrite && hitStatus;
    assign wrMask = accessDone && pwrite && hitMask;

    // Stable flag drops at once on disable, before the state catches up
    assign refStable = (state == DET_ARMED) && detectorPowerOn;

    always_comb begin
        readMux = '0;
        if (hitCtrl) begin
            readMux[`SD_BIT_DIR] = directionSel;
            readMux[`SD_BIT_BG] = bgStable;
            readMux[`SD_BIT_REF] = refStable;
            readMux[`SD_BIT_EN] = detectorPowerOn;
            readMux[`SD_LVL_MSB:`SD_LVL_LSB] = tripLevelSel;
        end else if (hitStatus) begin
            readMux[`SD_BIT_EVENT] = eventFlag;
        end else if (hitMask) begin
            readMux[`SD_BIT_EVENT] = intEnable;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else begin
            pready <= setupPhase;
            pslverr <= setupPhase && !(hitCtrl || hitStatus || hitMask);
            if (setupPhase && !pwrite) begin
                prdata <= readMux;
            end else begin
                prdata <= '0;
            end
        end
    end

    // Read-only bits 6 and 5 ignore writes
    always_comb begin
        next_powerOn = detectorPowerOn;
        next_direction = directionSel;
        next_level = tripLevelSel;
        if (wrCtrl) begin
            next_powerOn = pwdata[`SD_BIT_EN];
            next_direction = pwdata[`SD_BIT_DIR];
            next_level = pwdata[`SD_LVL_MSB:`SD_LVL_LSB];
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            detectorPowerOn <= 1'(`SD_CTRL_RST >> `SD_BIT_EN);
            directionSel <= 1'(`SD_CTRL_RST >> `SD_BIT_DIR);
            tripLevelSel <= 4'(`SD_CTRL_RST);
            externalInputSel <= (4'(`SD_CTRL_RST) == `SD_LVL_EXT);
        end else begin
            detectorPowerOn <= next_powerOn;
            directionSel <= next_direction;
            tripLevelSel <= next_level;
            externalInputSel <= (next_level == `SD_LVL_EXT);
        end
    end

    // Detector sequencing: off, settling reference, armed
    always_comb begin
        next_state = state;
        case (state)
            DET_OFF: begin
                if (detectorPowerOn) begin
                    next_state = DET_SETTLE;
                end
            end
            DET_SETTLE: begin
                if (!detectorPowerOn) begin
                    next_state = DET_OFF;
                end else if (timerDone) begin
                    next_state = DET_ARMED;
                end
            end
            DET_ARMED: begin
                if (!detectorPowerOn) begin
                    next_state = DET_OFF;
                end
            end
            default: begin
                next_state = DET_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= DET_OFF;
        end else begin
            state <= next_state;
        end
    end

    // No clock gating here, so the detector keeps working through sleep
    assign trip = refStable && (directionSel ? syncAbove : syncBelow);

    // A crossing in the clearing cycle still leaves the flag set
    always_comb begin
        next_eventFlag = eventFlag;
        if (wrStatus && pwdata[`SD_BIT_EVENT]) begin
            next_eventFlag = 1'b0;
        end
        if (trip) begin
            next_eventFlag = 1'b1;
        end
        next_intEnable = wrMask ? pwdata[`SD_BIT_EVENT] : intEnable;
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            eventFlag <= `SD_STATUS_RST;
            intEnable <= `SD_MASK_RST;
        end else begin
            eventFlag <= next_eventFlag;
            intEnable <= next_intEnable;
        end
    end

    // Interrupt tracks the flag without lag; wake is a pulse on each new event
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq <= 1'b0;
            wakeRequest <= 1'b0;
        end else begin
            irq <= next_eventFlag && next_intEnable;
            wakeRequest <= next_eventFlag && !eventFlag;
        end
    end

    // Cycles since power-on, saturating; only the checks read it
    logic [8:0] onCycles;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            onCycles <= '0;
        end else if (!detectorPowerOn) begin
            onCycles <= '0;
        end else if (onCycles != 9'h1ff) begin
            onCycles <= onCycles + 9'h001;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking

    default disable iff (sys_rst);

    a_power_write: assert property (
        wrCtrl |=> detectorPowerOn == $past(pwdata[`SD_BIT_EN]))
        else $error("power enable did not follow control write");

    a_ref_not_early: assert property (
        refStable |-> onCycles >= STAB)
        else $error("reference stable before settling interval");

    a_ref_in_time: assert property (
        (detectorPowerOn && onCycles >= STAB + 2) |-> refStable)
        else $error("reference stable flag late");

    a_event_needs_ref: assert property (
        $rose(eventFlag) |-> $past(refStable))
        else $error("event flag set without stable reference");

    a_fall_detect: assert property (
        (refStable && !directionSel && syncBelow) |=> eventFlag)
        else $error("falling crossing missed");

    a_rise_detect: assert property (
        (refStable && directionSel && syncAbove) |=> eventFlag)
        else $error("rising crossing missed");

    a_ext_route: assert property (
        externalInputSel == (tripLevelSel == `SD_LVL_EXT))
        else $error("external input select mismatch");

    a_irq_gate: assert property (
        irq == (eventFlag && intEnable))
        else $error("interrupt does not match flag and enable");

    a_bg_read: assert property (
        (setupPhase && !pwrite && hitCtrl) |=> prdata[`SD_BIT_BG] == $past(bgStable))
        else $error("band gap flag read wrong");

    a_flag_sticky: assert property (
        (eventFlag && !(wrStatus && pwdata[`SD_BIT_EVENT])) |=> eventFlag)
        else $error("event flag lost without a clear");

    a_wake_pulse: assert property (
        $rose(eventFlag) |-> wakeRequest ##1 !wakeRequest)
        else $error("wake pulse missing or too long");

    // Settling ends a fixed count after power-on, neither sooner nor later
    a_ref_exact: assert property (
        $rose(refStable) |-> onCycles == 9'(STAB + 2))
        else $error("reference stable rose at the wrong cycle");

    a_power_off: assert property (
        !detectorPowerOn |=> state == DET_OFF)
        else $error("detector not idle while powered down");

    a_quiet_unarmed: assert property (
        !refStable |=> !wakeRequest)
        else $error("wake raised without stable reference");

    a_dir_write: assert property (
        wrCtrl |=> directionSel == $past(pwdata[`SD_BIT_DIR]))
        else $error("direction did not follow control write");

    a_level_write: assert property (
        wrCtrl |=> tripLevelSel == $past(pwdata[`SD_LVL_MSB:`SD_LVL_LSB]))
        else $error("trip level did not follow control write");

    a_mask_write: assert property (
        wrMask |=> intEnable == $past(pwdata[`SD_BIT_EVENT]))
        else $error("interrupt enable did not follow mask write");

    a_clear_flag: assert property (
        (wrStatus && pwdata[`SD_BIT_EVENT] && !trip) |=> !eventFlag)
        else $error("event flag survived a clear");

    a_ready_follow: assert property (
        setupPhase |=> pready)
        else $error("ready missing after setup cycle");

    a_unmapped_err: assert property (
        (setupPhase && !(hitCtrl || hitStatus || hitMask)) |=> pslverr && prdata == '0)
        else $error("unmapped access not refused");

    c_ref_rise: cover property ($rose(refStable));
    c_event_set: cover property ($rose(eventFlag));
    c_irq_high: cover property ($rose(irq));
    c_bus_error: cover property (pready && pslverr);
    c_fall_event: cover property ($rose(eventFlag) && !directionSel);

endmodule : supply_threshold_detect_ctrl

`default_nettype wire

/* test/supply_threshold_detect_ctrl_test.sv */
`timescale 1ns/100ps
`default_nettype none
`include "supply_detect_cfg.svh"

module supply_threshold_detect_ctrl_test;
    import supply_detect_pkg::*;

    localparam apb_addr_t CTRL = `SD_ADDR_CTRL;
    localparam apb_addr_t STAT = `SD_ADDR_STATUS;
    localparam apb_addr_t MASK = `SD_ADDR_MASK;
    localparam apb_addr_t HOLE = `SD_ADDR_MASK + 16'h0004;

    logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, rdErr;
    apb_addr_t paddr;
    apb_data_t pwdata, prdata, rdData;
    logic cmpAtOrAbove, cmpAtOrBelow, bandgapReady, detectorPowerOn;
    logic externalInputSel, directionSel, irq, wakeRequest;
    trip_level_t tripLevelSel;
    int nErrors = 0;
    int numChecks = 0;
    int cyc = 0;

    supply_threshold_detect_ctrl i_dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cmpAtOrAbove(cmpAtOrAbove),
        .cmpAtOrBelow(cmpAtOrBelow), .bandgapReady(bandgapReady),
        .detectorPowerOn(detectorPowerOn), .tripLevelSel(tripLevelSel),
        .externalInputSel(externalInputSel), .directionSel(directionSel),
        .irq(irq), .wakeRequest(wakeRequest)
    );

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) cyc <= cyc + 1;

    task summarize;
        $display("Checks: %0d, errors: %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize

    task chk(input apb_data_t got, input apb_data_t exp, input string what);
        numChecks++;
        if (got !== exp) begin
            nErrors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Entered right after a rising edge; returns one edge after the access edge
    task apb(input logic w, input apb_addr_t a, input apb_data_t d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdData = prdata;
        rdErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            nErrors++;
            $display("wrong value at %0t: no ready", $time);
            summarize();
        end else begin
            @(posedge sys_clk);
        end
    endtask : apb

    task wr(input apb_addr_t a, input apb_data_t d);
        apb(1'b1, a, d);
    endtask : wr

    task rd(input apb_addr_t a, input apb_data_t exp, input logic expErr);
        apb(1'b0, a, '0);
        chk(rdData, exp, "read data");
        chk(apb_data_t'(rdErr), apb_data_t'(expErr), "slave error");
    endtask : rd

    task waitWake;
        int n;
        n = 0;
        while (wakeRequest !== 1'b1 && n < 20) begin
            @(posedge sys_clk);
            n++;
        end
        chk(apb_data_t'(wakeRequest), 32'h1, "wake pulse");
        if (n >= 20) summarize();
    endtask : waitWake

    initial begin
        repeat (60000) @(posedge sys_clk);
        nErrors++;
        $display("wrong value at %0t: run timeout", $time);
        summarize();
    end

    initial begin
        int n;
        sys_rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        cmpAtOrAbove = 1'b0;
        cmpAtOrBelow = 1'b0;
        bandgapReady = 1'b0;
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(posedge sys_clk);
        chk(apb_data_t'({detectorPowerOn, tripLevelSel, irq, wakeRequest}), 32'h0, "reset");
        rd(CTRL, 32'h0, 1'b0);
        rd(STAT, 32'h0, 1'b0);
        rd(MASK, 32'h0, 1'b0);
        wr(HOLE, 32'hff);
        rd(HOLE, 32'h0, 1'b1);
        bandgapReady <= 1'b1;
        repeat (6) @(posedge sys_clk);
        rd(CTRL, 32'h40, 1'b0);
        // Sweep levels with the detector off, as setup order expects
        for (int i = 0; i < 16; i++) begin
            wr(CTRL, apb_data_t'(8'h80 | i));
            chk(apb_data_t'({tripLevelSel, externalInputSel, directionSel, detectorPowerOn}),
                apb_data_t'({i[3:0], i == 15, 1'b1, 1'b0}), "level");
        end
        wr(CTRL, 32'hf5);
        n = cyc;
        cmpAtOrAbove <= 1'b1;
        rd(CTRL, 32'hd5, 1'b0);
        chk(apb_data_t'(detectorPowerOn), 32'h1, "power on");
        repeat (120) @(posedge sys_clk);
        rd(STAT, 32'h0, 1'b0);
        chk(apb_data_t'({irq, wakeRequest}), 32'h0, "quiet while settling");
        cmpAtOrAbove <= 1'b0;
        do begin
            apb(1'b0, CTRL, '0);
        end while (rdData[5] !== 1'b1 && cyc - n < 400);
        chk(rdData, 32'hf5, "reference stable");
        chk(apb_data_t'(cyc - n >= `SD_STAB_CYC && cyc - n <= `SD_STAB_CYC + 8), 32'h1,
            "settle time");
        if (cyc - n >= 400) summarize();
        rd(STAT, 32'h0, 1'b0);
        wr(STAT, 32'h1);
        wr(MASK, 32'h1);
        cmpAtOrAbove <= 1'b1;
        waitWake();
        rd(STAT, 32'h1, 1'b0);
        chk(apb_data_t'(irq), 32'h1, "irq raised");
        // Clearing while the condition holds must not lose the event
        wr(STAT, 32'h1);
        rd(STAT, 32'h1, 1'b0);
        cmpAtOrAbove <= 1'b0;
        repeat (8) @(posedge sys_clk);
        rd(STAT, 32'h1, 1'b0);
        wr(STAT, 32'h1);
        rd(STAT, 32'h0, 1'b0);
        chk(apb_data_t'(irq), 32'h0, "irq cleared");
        wr(CTRL, 32'h15);
        cmpAtOrAbove <= 1'b1;
        repeat (10) @(posedge sys_clk);
        rd(STAT, 32'h0, 1'b0);
        cmpAtOrBelow <= 1'b1;
        waitWake();
        wr(MASK, 32'h0);
        rd(STAT, 32'h1, 1'b0);
        chk(apb_data_t'(irq), 32'h0, "irq masked");
        cmpAtOrBelow <= 1'b0;
        cmpAtOrAbove <= 1'b0;
        wr(CTRL, 32'h0);
        chk(apb_data_t'(detectorPowerOn), 32'h0, "power off");
        rd(CTRL, 32'h40, 1'b0);
        wr(CTRL, 32'h95);
        wr(MASK, 32'h1);
        sys_rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk(apb_data_t'({detectorPowerOn, tripLevelSel, directionSel, irq}), 32'h0, "rerun");
        sys_rst <= 1'b0;
        repeat (6) @(posedge sys_clk);
        rd(CTRL, 32'h40, 1'b0);
        rd(MASK, 32'h0, 1'b0);
        summarize();
    end
endmodule : supply_threshold_detect_ctrl_test

`default_nettype wire
